// [verilog/dsc_conv_seq.v]
//Contract
//- A conversion takes 19 rising bit clock edges after convert; extras harmless.
//- Bit clock edges after the 19th are ignored until next convert edge.
//- On the 19th edge both channels go to track until next convert.
//- The MSB decision settles on the first bit clock edge after convert.
//- Convert rising edge starts conversion and puts both channels in hold.
//- Only rising bit clock edges act; any duty cycle is tolerated.
//- Results are 18-bit two's complement: 1FFFF, 20000, zero as zeros.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_seq_regs.vh"
// Conversion sequencer for two successive approximation channels.
// Convert and bit clock arrive as pins and are sampled by clk; all
// decisions are taken on detected rising edges of those pins. The
// serial outputs carry the result of the previous conversion, so a
// controller reads frame N while frame N+1 is being converted.
module dsc_conv_seq #(
  parameter RES_BITS = `DSC_RES_BITS
) (
  input  wire clk,
  input  wire rst_b,
  input  wire convertStrobePin,
  input  wire bitClockPin,
  input  wire compLeft,
  input  wire compRight,
  output reg  holdQ,
  output reg  busyQ,
  output reg  serLeftQ,
  output reg  serRightQ,
  output reg  doneQ
);
  // One-hot sequencer states. TRACK is idle after reset, CONV counts
  // bit clock edges, LOCK holds off surplus edges until the next
  // convert edge. Only convert edges leave TRACK or LOCK.
  localparam [2:0] ST_TRACK = 3'b001;
  localparam [2:0] ST_CONV  = 3'b010;
  localparam [2:0] ST_LOCK  = 3'b100;

  reg        rstMetaB;
  reg        rstSyncB;
  reg        cnvMeta;
  reg        cnvSync;
  reg        cnvLast;
  reg        clkMeta;
  reg        clkSync;
  reg        clkLast;
  reg [2:0]  stateQ;
  reg [2:0]  stateD;
  reg [4:0]  edgeCntQ;
  reg [RES_BITS-1:0] shLeftQ;
  reg [RES_BITS-1:0] shRightQ;
  wire [RES_BITS-1:0] resLeft;
  wire [RES_BITS-1:0] resRight;
  wire       cnvRise;
  wire       clkRise;
  wire       convEdge;
  wire       lastEdge;
  wire       shiftEdge;

  //////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  // Assertion acts at once; release waits two clocks so that every
  // flop of the block leaves reset on the same clean edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMetaB <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMetaB <= 1'b1;
      rstSyncB <= rstMetaB;
    end
  end

  // Pin synchronisers and edge history
  // Both pins come from outside this clock: two flops each guard
  // against metastability, the third keeps the history for edges
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      cnvMeta <= 1'b0;
      cnvSync <= 1'b0;
      cnvLast <= 1'b0;
      clkMeta <= 1'b0;
      clkSync <= 1'b0;
      clkLast <= 1'b0;
    end else begin
      cnvMeta <= convertStrobePin;
      cnvSync <= cnvMeta;
      cnvLast <= cnvSync;
      clkMeta <= bitClockPin;
      clkSync <= clkMeta;
      clkLast <= clkSync;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Rise of a synchronised level against its one-cycle history
  function riseOf;
    input cur;
    input prev;
    begin
      riseOf = cur & ~prev;
    end
  endfunction

  // Rising edges only; a falling pin edge never acts, so the
  // duty cycle of either pin does not matter
  assign cnvRise  = riseOf(cnvSync, cnvLast);
  assign clkRise  = riseOf(clkSync, clkLast);
  // Clock edges count only while converting
  assign convEdge = clkRise & ~cnvRise & (stateQ == ST_CONV);
  // Nineteenth counted edge ends the conversion
  assign lastEdge = convEdge && (edgeCntQ == `DSC_CONV_EDGES - 5'd1);
  // Edges one to eighteen shift the previous result out
  assign shiftEdge = convEdge & ~lastEdge;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always @* begin
    stateD = stateQ;
    case (stateQ)
      ST_TRACK: begin
        // Idle in track; bit clock edges here are ignored
        if (cnvRise)
          stateD = ST_CONV;
      end
      ST_CONV: begin
        // Converting; a new convert edge restarts the count
        if (cnvRise)
          stateD = ST_CONV;                             // Restart
        else if (lastEdge)
          stateD = ST_LOCK;
      end
      ST_LOCK: begin
        // Lockout: only a new convert edge leaves this state
        if (cnvRise)
          stateD = ST_CONV;
      end
      default: stateD = ST_TRACK;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer state register
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB)
      stateQ <= ST_TRACK;
    else
      stateQ <= stateD;
  end

  // Counted bit clock edges; cleared by every convert edge so that a
  // restart mid-conversion begins a fresh cycle of edges
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB)
      edgeCntQ <= 5'd0;
    else if (cnvRise)
      edgeCntQ <= 5'd0;
    else if (convEdge)
      edgeCntQ <= edgeCntQ + 5'd1;
  end

  // Hold and busy follow the sequencer; done marks the last edge
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      holdQ <= 1'b0;
      busyQ <= 1'b0;
      doneQ <= 1'b0;
    end else begin
      doneQ <= lastEdge;
      if (cnvRise) begin
        holdQ <= 1'b1;
        busyQ <= 1'b1;
      end else if (lastEdge) begin
        holdQ <= 1'b0;
        busyQ <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Both channels; first counted edge decides the MSB
  // Left channel
  dsc_sar_chan #(
    .WIDTH      (RES_BITS)
  ) uLeft (
    .clk        (clk),
    .rstSyncB   (rstSyncB),
    .startPulse (cnvRise),
    .stepPulse  (convEdge),
    .compIn     (compLeft),
    .resultQ    (resLeft)
  );

  // Right channel, stepped on the very same edges as the left
  dsc_sar_chan #(
    .WIDTH      (RES_BITS)
  ) uRight (
    .clk        (clk),
    .rstSyncB   (rstSyncB),
    .startPulse (cnvRise),
    .stepPulse  (convEdge),
    .compIn     (compRight),
    .resultQ    (resRight)
  );

  //////////////////////////////////////////////////////////////////////////
  // Serial output: previous result, MSB first, one bit per edge
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      shLeftQ   <= {RES_BITS{1'b0}};
      shRightQ  <= {RES_BITS{1'b0}};
      serLeftQ  <= 1'b0;
      serRightQ <= 1'b0;
    end else if (lastEdge) begin
      shLeftQ   <= resLeft;
      shRightQ  <= resRight;
    end else if (shiftEdge) begin
      // Edge 19 loads the new result, edges 1 to 18 shift it out
      serLeftQ  <= shLeftQ[RES_BITS-1];
      serRightQ <= shRightQ[RES_BITS-1];
      shLeftQ   <= {shLeftQ[RES_BITS-2:0], 1'b0};
      shRightQ  <= {shRightQ[RES_BITS-2:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// [verilog/dsc_seq_regs.vh]
`ifndef DSC_SEQ_REGS_VH
`define DSC_SEQ_REGS_VH
// Conversion length in rising bit clock edges
`define DSC_CONV_EDGES     5'd19
// Result width
`define DSC_RES_BITS       18
// Coding reference points, two's complement
`define DSC_POS_FULL       18'h1FFFF
`define DSC_NEG_FULL       18'h20000
`define DSC_ZERO_CODE      18'h00000
// Convert low deadline before 19th edge, in ns
`define DSC_CONV_LOW_NS    50
`endif

// [verilog/dsc_sar_chan.v]
`timescale 1ns/1ps
`default_nettype none
`include "dsc_seq_regs.vh"
// One channel of the successive approximation register
module dsc_sar_chan #(
  parameter WIDTH = `DSC_RES_BITS
) (
  input  wire             clk,
  input  wire             rstSyncB,
  input  wire             startPulse,
  input  wire             stepPulse,
  input  wire             compIn,
  output reg  [WIDTH-1:0] resultQ
);
  reg [WIDTH-1:0] trialQ;

  // Trial bit walks from MSB down; a start reloads the walk
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      trialQ  <= {WIDTH{1'b0}};
      resultQ <= {WIDTH{1'b0}};
    end else if (startPulse) begin
      trialQ  <= {1'b1, {(WIDTH-1){1'b0}}};
      resultQ <= {WIDTH{1'b0}};
    end else if (stepPulse && (trialQ != {WIDTH{1'b0}})) begin
      // Keep or reject the trial bit; MSB is the sign
      if (compIn)
        resultQ <= resultQ | trialQ;
      trialQ <= trialQ >> 1;
    end
  end
endmodule
`default_nettype wire

// [tb/dsc_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dsc_seq_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic convertStrobePin,
  input wire logic bitClockPin,
  input wire logic compLeft,
  input wire logic compRight,
  input wire logic holdQ,
  input wire logic busyQ,
  input wire logic serLeftQ,
  input wire logic serRightQ,
  input wire logic doneQ
);
  reg [2:0] bSyncQ;
  reg [2:0] cSyncQ;
  reg [4:0] edgeCntQ;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Counts synced bit clock rises while in hold
  always @(posedge clk) begin
    bSyncQ <= {bSyncQ[1:0], bitClockPin};
    cSyncQ <= {cSyncQ[1:0], convertStrobePin};
    if (cSyncQ[1] && !cSyncQ[2])
      edgeCntQ <= 5'h00;
    else if (holdQ && bSyncQ[1] && !bSyncQ[2])
      edgeCntQ <= edgeCntQ + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_hold_busy_same: assert property (
    holdQ == busyQ) else $error("hold and busy differ");
  chk_conv_holds: assert property (
    $rose(convertStrobePin) |-> ##[2:5] holdQ) else $error("no hold");
  chk_hold_cause: assert property (
    $rose(holdQ) |-> $past(convertStrobePin, 2)) else $error("stray hold");
  chk_track_kept: assert property (
    !holdQ && !convertStrobePin |=> !holdQ) else $error("left track");
  chk_done_once: assert property (
    doneQ |=> !doneQ) else $error("done too long");
  chk_done_track: assert property (
    doneQ |-> !holdQ && $past(holdQ)) else $error("done without track");
  chk_count_end: assert property (
    doneQ |-> edgeCntQ == 5'h13) else $error("wrong edge count");
  chk_no_early: assert property (
    holdQ && edgeCntQ < 5'h13 &&
    !(edgeCntQ == 5'h12 && bSyncQ[1] && !bSyncQ[2]) |=> holdQ)
    else $error("early end");
  chk_ser_idle: assert property (
    !holdQ && !$past(holdQ) && !$past(holdQ, 2) |->
    $stable(serLeftQ) && $stable(serRightQ)) else $error("serial moved");
  cov_start: cover property ($rose(holdQ));
  cov_done: cover property (doneQ);
  cov_extra: cover property (!holdQ && bSyncQ[1] && !bSyncQ[2]);
endmodule
bind dsc_conv_seq dsc_seq_assertions u_chk (
  .clk(clk), .rst_b(rst_b), .convertStrobePin(convertStrobePin),
  .bitClockPin(bitClockPin), .compLeft(compLeft), .compRight(compRight),
  .holdQ(holdQ), .busyQ(busyQ), .serLeftQ(serLeftQ),
  .serRightQ(serRightQ), .doneQ(doneQ));
`default_nettype wire

// [tb/dsc_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsc_ctl_model (
  input  wire logic   clk,
  input  wire logic   serLeft,
  input  wire logic   serRight,
  output logic        convertStrobe,
  output logic        bitClock,
  output logic        compL,
  output logic        compR,
  output logic [17:0] capL,
  output logic [17:0] capR
);
  // Idle pins, clock stopped between frames
  initial begin
    {convertStrobe, bitClock, compL, compR} = 4'h0;
    {capL, capR} = 36'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One frame: convert pulse, guard gap, then n bit clock rises
  task automatic convert(input logic [17:0] l, input logic [17:0] r,
                         input int n);
    @(posedge clk) convertStrobe <= 1'b1;
    repeat (10) @(posedge clk);
    convertStrobe <= 1'b0;
    repeat (12) @(posedge clk);
    for (int k = 1; k <= n; k++) begin
      compL <= l[17];
      compR <= r[17];
      l = {l[16:0], 1'b0};
      r = {r[16:0], 1'b0};
      repeat (8) @(posedge clk);
      bitClock <= 1'b1;
      if (k >= 2 && k <= 19) begin
        capL <= {capL[16:0], serLeft};
        capR <= {capR[16:0], serRight};
      end
      repeat (8) @(posedge clk);
      bitClock <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic       clk;
  logic       rst_b;
  wire        cvt, bck, cmpL, cmpR, hold, busy, serL, serR, done;
  wire [17:0] capL, capR;
  int         err_total = 0;
  int         num_checks = 0;
  dsc_conv_seq u_dut (.clk(clk), .rst_b(rst_b), .convertStrobePin(cvt),
    .bitClockPin(bck), .compLeft(cmpL), .compRight(cmpR), .holdQ(hold),
    .busyQ(busy), .serLeftQ(serL), .serRightQ(serR), .doneQ(done));
  dsc_ctl_model u_ctl (.clk(clk), .serLeft(serL), .serRight(serR),
    .convertStrobe(cvt), .bitClock(bck), .compL(cmpL), .compR(cmpR),
    .capL(capL), .capR(capR));
  ////////////////////////////////////////////////////////////////////////////
  // Full scale codes shifted out in the following frame
  task automatic sc_codes();
    u_ctl.convert(18'h1FFFF, 18'h20000, 19);
    `CHK(hold, 1'b0)
    u_ctl.convert(18'h00000, 18'h3FFFF, 19);
    `CHK(capL, 18'h1FFFF)
    `CHK(capR, 18'h20000)
    u_ctl.convert(18'h2AAAA, 18'h15555, 19);
    `CHK(capL, 18'h00000)
    `CHK(capR, 18'h3FFFF)
  endtask
  // Surplus bit clock rises must leave result and track mode alone
  task automatic sc_extra();
    u_ctl.convert(18'h0F0F0, 18'h30303, 25);
    `CHK(hold, 1'b0)
    `CHK(capL, 18'h2AAAA)
    u_ctl.convert(18'h00000, 18'h00000, 19);
    `CHK(capL, 18'h0F0F0)
    `CHK(capR, 18'h30303)
  endtask
  // A convert edge mid-conversion restarts with a fresh result
  task automatic sc_restart();
    u_ctl.convert(18'h3FFFF, 18'h3FFFF, 5);
    u_ctl.convert(18'h12345, 18'h0A5A5, 19);
    `CHK(hold, 1'b0)
    u_ctl.convert(18'h00000, 18'h00000, 19);
    `CHK(capL, 18'h12345)
    `CHK(capR, 18'h0A5A5)
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    sc_codes();
    sc_extra();
    sc_restart();
    give_verdict();
  end
  // Watchdog well beyond eight frames
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
